/* hw/cadc_top.sv */
`timescale 1ns/10ps
`include "cadc_regs.svh"
module cadc_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire cadc_pkg::cadc_pins_t pins,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic result_ready_n,
    output logic busy,
    output logic inputs_connected,
    output logic charge_inject,
    output logic [2:0] integrate_toggle_chan,
    output logic chain_out,
    output logic speed_power_sel
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    cadc_pkg::cadc_pins_t s1_r;
    cadc_pkg::cadc_pins_t s2_r;
    cadc_pkg::cadc_pins_t s3_r;
    // Stage one feeds only stage two; edges compare stages two and three.
    // No reset here: the stages track the pins through reset, so the toggle level
    // seen at release is the real one and no false edge follows release.
    always_ff @(posedge clk) begin
        if (ce) begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    logic tog;
    logic tog_chg;
    logic strobe_rise;
    logic sclk_fall;
    assign tog = s2_r.integrate_toggle;
    assign tog_chg = s2_r.integrate_toggle ^ s3_r.integrate_toggle;
    assign strobe_rise = s2_r.test_strobe & ~s3_r.test_strobe;
    assign sclk_fall = s3_r.shift_clock & ~s2_r.shift_clock;

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    logic [1:0] ctrl_r;
    logic [1:0] ctrl_nxt;
    logic wr_go;
    logic wr_hit;
    assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~s_axi_awready;
    assign wr_hit = s_axi_awaddr == `CADC_ADDR_CTRL;
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_go && wr_hit && s_axi_wstrb[0]) begin
            ctrl_nxt = s_axi_wdata[1:0];
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_r <= `CADC_CTRL_RESET;
        end else if (ce) begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // ----------------------------------------
    // Pre-divider
    // ----------------------------------------
    // One enable paces every internal count, so all timing scales together.
    logic [1:0] div_r;
    logic tick;
    assign tick = ce & (~ctrl_r[`CADC_CTRL_PREDIV] | (div_r == `CADC_PREDIV_LAST));
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_r <= '0;
        end else if (ce) begin
            div_r <= div_r + 2'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            speed_power_sel <= 1'b0;
        end else if (ce) begin
            speed_power_sel <= ctrl_r[`CADC_CTRL_SPEED];
        end
    end

    // ----------------------------------------
    // Integrate and measure sequencer
    // ----------------------------------------
    cadc_pkg::cadc_state_t state_r;
    cadc_pkg::cadc_state_t state_nxt;
    logic [11:0] busy_r;
    logic [11:0] rdy_r;
    logic start_r;
    logic mbsy;
    assign mbsy = busy_r != '0;
    // Moves follow the toggle level, not its edges.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            cadc_pkg::CADC_NC_A: if (!mbsy) state_nxt = cadc_pkg::CADC_PREP_A;
            cadc_pkg::CADC_PREP_A: if (tog) state_nxt = cadc_pkg::CADC_INT_A;
            cadc_pkg::CADC_INT_A: if (!tog) state_nxt = cadc_pkg::CADC_IB_MA;
            cadc_pkg::CADC_IB_MA: if (tog) begin
                state_nxt = mbsy ? cadc_pkg::CADC_NC_A : cadc_pkg::CADC_IA_MB;
            end
            cadc_pkg::CADC_IA_MB: if (!tog) begin
                state_nxt = mbsy ? cadc_pkg::CADC_NC_B : cadc_pkg::CADC_IB_MA;
            end
            cadc_pkg::CADC_INT_B: if (tog) state_nxt = cadc_pkg::CADC_IA_MB;
            cadc_pkg::CADC_PREP_B: if (!tog) state_nxt = cadc_pkg::CADC_INT_B;
            cadc_pkg::CADC_NC_B: if (!mbsy) state_nxt = cadc_pkg::CADC_PREP_B;
        endcase
    end
    // The power-up state comes from the toggle level seen after reset release.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= cadc_pkg::CADC_NC_B;
            start_r <= 1'b1;
        end else if (tick) begin
            start_r <= 1'b0;
            if (start_r) begin
                state_r <= tog ? cadc_pkg::CADC_NC_A : cadc_pkg::CADC_NC_B;
            end else begin
                state_r <= state_nxt;
            end
        end
    end
    logic enter_cont;
    logic enter_nc;
    assign enter_cont = (state_nxt != state_r) & ~start_r &
        (state_nxt == cadc_pkg::CADC_IB_MA || state_nxt == cadc_pkg::CADC_IA_MB);
    assign enter_nc = (state_nxt != state_r) & ~start_r &
        (state_nxt == cadc_pkg::CADC_NC_A || state_nxt == cadc_pkg::CADC_NC_B);
    // Measure cycle length; a late toggle stretches it to the longer figure.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_r <= '0;
        end else if (tick) begin
            if (enter_cont) begin
                busy_r <= `CADC_T_MRAZ_CONT;
            end else if (enter_nc) begin
                busy_r <= `CADC_T_MRAZ_NCONT;
            end else if (mbsy) begin
                busy_r <= busy_r - 12'h001;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy <= 1'b0;
        end else if (ce) begin
            busy <= mbsy;
        end
    end
    // Eight channels on four engines: engine is the low two bits.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            integrate_toggle_chan <= '0;
        end else if (tick && mbsy) begin
            integrate_toggle_chan <= integrate_toggle_chan + 3'h1;
        end
    end

    // ----------------------------------------
    // Ready flag and readout side
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdy_r <= '0;
        end else if (tick) begin
            if (enter_cont) begin
                rdy_r <= `CADC_T_READY_CONT;
            end else if (enter_nc) begin
                rdy_r <= `CADC_T_READY_NCONT;
            end else if (rdy_r != '0) begin
                rdy_r <= rdy_r - 12'h001;
            end
        end
    end
    // A new result wins over a shift clock fall in the same cycle.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            result_ready_n <= 1'b1;
        end else if (ce) begin
            if (tick && rdy_r == 12'h001) begin
                result_ready_n <= 1'b0;
            end else if (sclk_fall) begin
                result_ready_n <= 1'b1;
            end
        end
    end
    // Chain data moves on the shift clock only, never on the sequencer.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chain_out <= 1'b0;
        end else if (ce && sclk_fall) begin
            chain_out <= s2_r.chain_in;
        end
    end

    // ----------------------------------------
    // Test mode
    // ----------------------------------------
    logic test_mode_r;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            test_mode_r <= 1'b0;
        end else if (ce && tog_chg) begin
            test_mode_r <= s2_r.test_strobe;
        end
    end
    // Non-continuous states ground the inputs as well.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            inputs_connected <= 1'b0;
        end else if (ce) begin
            inputs_connected <= ~test_mode_r & (state_r == cadc_pkg::CADC_INT_A ||
                state_r == cadc_pkg::CADC_IB_MA || state_r == cadc_pkg::CADC_IA_MB ||
                state_r == cadc_pkg::CADC_INT_B);
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            charge_inject <= 1'b0;
        end else if (ce) begin
            charge_inject <= test_mode_r & strobe_rise;
        end
    end

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    cadc_pkg::cadc_status_t stat;
    assign stat = '{chan: integrate_toggle_chan, test_mode: test_mode_r, cont_mode: inputs_connected |
        test_mode_r, busy: mbsy, ready: ~result_ready_n, state: state_r};
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CADC_RESP_OKAY;
        end else if (ce) begin
            s_axi_awready <= wr_go;
            s_axi_wready <= wr_go;
            // The response waits until address and data have been taken.
            if (s_axi_awready) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `CADC_RESP_OKAY : `CADC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    logic rd_go;
    assign rd_go = s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `CADC_RESP_OKAY;
        end else if (ce) begin
            s_axi_arready <= rd_go;
            // Data follow the address handshake; the master still holds the address.
            if (s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `CADC_RESP_OKAY;
                s_axi_rdata <= '0;
                if (s_axi_araddr == `CADC_ADDR_CTRL) begin
                    s_axi_rdata <= {30'h0000_0000, ctrl_r};
                end else if (s_axi_araddr == `CADC_ADDR_STATUS) begin
                    s_axi_rdata <= {22'h00_0000, stat};
                end else begin
                    s_axi_rresp <= `CADC_RESP_SLVERR;
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_PREDIV_ONE: assert property (@(posedge clk) disable iff (!rst_n)
        ce && !ctrl_r[`CADC_CTRL_PREDIV] |-> tick) else $error("Undivided clock missed a tick.");
    AST_PREDIV_FOUR: assert property (@(posedge clk) disable iff (!rst_n)
        ce && ctrl_r[`CADC_CTRL_PREDIV] && tick ##1 ce[*3] |-> !$past(tick) && !tick)
        else $error("Divided tick too frequent.");
    AST_TEST_ENTER: assert property (@(posedge clk) disable iff (!rst_n)
        ce && tog_chg && s2_r.test_strobe |=> test_mode_r) else $error("Test mode not entered.");
    AST_TEST_ISOLATE: assert property (@(posedge clk) disable iff (!rst_n)
        ce && test_mode_r |=> !inputs_connected) else $error("Inputs connected in test mode.");
    AST_INJECT: assert property (@(posedge clk) disable iff (!rst_n)
        ce && test_mode_r && strobe_rise |=> charge_inject) else $error("Charge packet missed.");
    AST_READY_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        !result_ready_n && !sclk_fall |=> !result_ready_n) else $error("Ready released early.");
    AST_READY_TIME: assert property (@(posedge clk) disable iff (!rst_n)
        tick && enter_cont |=> rdy_r == `CADC_T_READY_CONT)
        else $error("Ready timer not loaded with 1380.");
    AST_BUSY_CONT: assert property (@(posedge clk) disable iff (!rst_n)
        tick && enter_cont |=> busy_r == `CADC_T_MRAZ_CONT ##1 busy) else $error("Busy not raised.");
    AST_NONCONT: assert property (@(posedge clk) disable iff (!rst_n)
        tick && !start_r && state_r == cadc_pkg::CADC_IB_MA && tog && mbsy
        |=> state_r == cadc_pkg::CADC_NC_A) else $error("Late toggle kept continuous mode.");
    AST_ENGINE: assert property (@(posedge clk) disable iff (!rst_n)
        tick && mbsy |=> integrate_toggle_chan == $past(integrate_toggle_chan) + 3'h1) else $error("Channel stalled.");
endmodule // cadc_top

/* shared/cadc_regs.svh */
`ifndef CADC_REGS_SVH
`define CADC_REGS_SVH
`define CADC_ADDR_CTRL 4'h0
`define CADC_ADDR_STATUS 4'h4
`define CADC_CTRL_PREDIV 0
`define CADC_CTRL_SPEED 1
`define CADC_CTRL_RESET 2'h0
`define CADC_PREDIV_LAST 2'h3
`define CADC_T_MRAZ_CONT 12'h5BE
`define CADC_T_MRAZ_NCONT 12'hB55
`define CADC_T_READY_CONT 12'h564
`define CADC_T_READY_NCONT 12'h563
`define CADC_RESP_OKAY 2'h0
`define CADC_RESP_SLVERR 2'h2
`endif

/* shared/cadc_pkg.sv */
package cadc_pkg;
    // Sequencer states; symmetric pairs mirror each other under toggle inversion.
    typedef enum logic [2:0] {
        CADC_NC_A, CADC_PREP_A, CADC_INT_A, CADC_IB_MA,
        CADC_IA_MB, CADC_INT_B, CADC_PREP_B, CADC_NC_B
    } cadc_state_t;
    // Pins from the host, all asynchronous to clk.
    typedef struct packed {
        logic integrate_toggle;
        logic test_strobe;
        logic shift_clock;
        logic chain_in;
    } cadc_pins_t;
    // Status word as read back over the bus.
    typedef struct packed {
        logic [2:0] chan;
        logic test_mode;
        logic cont_mode;
        logic busy;
        logic ready;
        cadc_state_t state;
    } cadc_status_t;
endpackage

/* verification/cadc_host_model.sv */
`timescale 1ns/10ps
// ------
// Host side of the conversion control pins.
// ------
module cadc_host_model (
    input wire logic clk,
    output cadc_pkg::cadc_pins_t pins
);
    // 100 ns is 20 cycles and 1 us is 200 cycles; both carry margin.
    localparam int T_SET = 24;
    localparam int T_PH = 210;

    // All pins idle low, shift clock included, until a task moves them.
    initial begin
        pins = '0;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Toggle moves just after a clock edge, with the strobe settled around it.
    task automatic flip(input logic strobe);
        @(posedge clk);
        pins.test_strobe <= strobe;
        wt(T_SET);
        pins.integrate_toggle <= ~pins.integrate_toggle;
        wt(T_SET);
    endtask

    // One charge packet request: low then high, each phase over 1 us.
    task automatic strobe_pulse();
        @(posedge clk);
        pins.test_strobe <= 1'b0;
        wt(T_PH);
        pins.test_strobe <= 1'b1;
        wt(T_PH);
    endtask

    // Shift clock step; the chain bit is set up with every step, rising or falling.
    task automatic sclk(input logic v, input logic b);
        @(posedge clk);
        pins.chain_in <= b;
        pins.shift_clock <= v;
        wt(8);
    endtask
endmodule // cadc_host_model

/* verification/tb.sv */
`timescale 1ns/10ps
`include "cadc_regs.svh"
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    cadc_pkg::cadc_pins_t pins;
    logic [3:0] s_axi_awaddr = 4'h0;
    logic [3:0] s_axi_araddr = 4'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, d;
    logic [1:0] r;
    logic result_ready_n, busy, inputs_connected, charge_inject, chain_out;
    logic speed_power_sel;
    logic [2:0] integrate_toggle_chan;
    logic [2:0] ch0;
    logic ce = 1'b1;
    logic tog_q = 1'b0;
    logic rdy_q = 1'b1;
    int since = 0;
    int lat = 0;
    int inj_cnt = 0;
    int c0;
    int err_count = 0;
    int total_checks = 0;

    initial begin
        forever #2.5 clk = ~clk;
    end

    // Clock enable is dropped once mid-run to show that it freezes the sequencer.
    cadc_top cadc_top_i (.clk, .rst_n, .ce, .pins, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .result_ready_n, .busy, .inputs_connected, .charge_inject, .integrate_toggle_chan,
        .chain_out, .speed_power_sel);
    cadc_host_model cadc_host_model_i (.clk, .pins);

    // Latency from the last toggle change to the ready fall, and packet count.
    always @(posedge clk) begin
        tog_q <= pins.integrate_toggle;
        rdy_q <= result_ready_n;
        since <= (pins.integrate_toggle !== tog_q) ? 0 : since + 1;
        if (rdy_q === 1'b1 && result_ready_n === 1'b0) lat <= since;
        if (charge_inject === 1'b1) inj_cnt <= inj_cnt + 1;
    end

    // ------
    // Shared tasks
    // ------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // A hung handshake ends the run as a mismatch.
    task automatic lim(input int n);
        if (n >= 200) begin
            err_count++;
            wrap_up();
        end
    endtask

    task automatic axw(input logic [3:0] a, input logic [31:0] v, input logic [3:0] st);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            lim(n);
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic axr(input logic [3:0] a);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            lim(n);
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // One integration period; a pending result is shifted out at its end.
    task automatic per(input int n, input logic s);
        cadc_host_model_i.flip(s);
        repeat (n) @(posedge clk);
        if (result_ready_n === 1'b0) begin
            cadc_host_model_i.sclk(1'b1, 1'b0);
            cadc_host_model_i.sclk(1'b0, 1'b0);
        end
    endtask

    // ------
    // Main sequence
    // ------
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk(result_ready_n, 1'b1);
        chk(speed_power_sel, 1'b0);
        axr(`CADC_ADDR_CTRL);
        chk(d, 32'h0000_0000);
        $display("test reset done");
        axw(`CADC_ADDR_CTRL, 32'h0000_0002, 4'hF);
        chk(r, `CADC_RESP_OKAY);
        chk(speed_power_sel, 1'b1);
        axw(`CADC_ADDR_CTRL, 32'h0000_0000, 4'h0);
        chk(speed_power_sel, 1'b1);
        axw(4'h8, 32'h0000_0001, 4'hF);
        chk(r, `CADC_RESP_SLVERR);
        axr(4'hC);
        chk(r, `CADC_RESP_SLVERR);
        chk(d, 32'h0000_0000);
        $display("test bus done");
        repeat (4) per(2000, 1'b0);
        chk(32'(lat >= 1378 && lat <= 1390), 32'h0000_0001);
        ch0 = integrate_toggle_chan;
        cadc_host_model_i.flip(1'b0);
        chk(busy, 1'b1);
        chk(inputs_connected, 1'b1);
        ce <= 1'b0;
        repeat (2) @(posedge clk);
        c0 = integrate_toggle_chan;
        repeat (40) @(posedge clk);
        chk(integrate_toggle_chan, c0);
        ce <= 1'b1;
        repeat (1500) @(posedge clk);
        chk(result_ready_n, 1'b0);
        cadc_host_model_i.sclk(1'b1, 1'b1);
        chk(result_ready_n, 1'b0);
        cadc_host_model_i.sclk(1'b0, 1'b1);
        chk(result_ready_n, 1'b1);
        chk(chain_out, 1'b1);
        cadc_host_model_i.sclk(1'b1, 1'b0);
        cadc_host_model_i.sclk(1'b0, 1'b0);
        chk(chain_out, 1'b0);
        repeat (600) @(posedge clk);
        chk(3'(integrate_toggle_chan - ch0), 3'(`CADC_T_MRAZ_CONT));
        $display("test continuous done");
        repeat (3) per(800, 1'b0);
        axr(`CADC_ADDR_STATUS);
        chk(d[5], 1'b0);
        chk(inputs_connected, 1'b0);
        repeat (4) per(2000, 1'b0);
        axr(`CADC_ADDR_STATUS);
        chk(d[5], 1'b1);
        $display("test mode switch done");
        cadc_host_model_i.flip(1'b1);
        axr(`CADC_ADDR_STATUS);
        chk(d[6], 1'b1);
        chk(inputs_connected, 1'b0);
        c0 = inj_cnt;
        repeat (3) cadc_host_model_i.strobe_pulse();
        chk(inj_cnt - c0, 3);
        repeat (400) @(posedge clk);
        chk(result_ready_n, 1'b0);
        chk(32'(lat >= 1378 && lat <= 1390), 32'h0000_0001);
        cadc_host_model_i.sclk(1'b1, 1'b0);
        cadc_host_model_i.sclk(1'b0, 1'b0);
        per(2000, 1'b1);
        per(2000, 1'b0);
        axr(`CADC_ADDR_STATUS);
        chk(d[6], 1'b0);
        $display("test diagnostic done");
        axw(`CADC_ADDR_CTRL, 32'h0000_0001, 4'hF);
        repeat (3) per(7000, 1'b0);
        chk(32'(lat >= 5515 && lat <= 5545), 32'h0000_0001);
        $display("test prescaler done");
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk(result_ready_n, 1'b1);
        axr(`CADC_ADDR_CTRL);
        chk(d, 32'h0000_0000);
        repeat (4) per(2000, 1'b0);
        chk(32'(lat >= 1378 && lat <= 1390), 32'h0000_0001);
        $display("test second reset done");
        wrap_up();
    end
endmodule // tb
